// ==== shared/dtz_cfg.svh ====
// Behaviour
// - decode touch-for-load: opcode 31, xo 278
// - decode touch-for-store: opcode 31, xo 246
// - decode clear-block: opcode 31, xo 1014
// - address is index plus base, or zero base
// - touch to inhibited block completes as no-op
// - touches never raise alignment exception
// - locked mode: touch miss fills normal cache
// - touch translation fault suppresses fetch silently
// - touch skips referenced/changed bit update
// - touch fetch optional, drop invisible
// - touches differ only in bus type
// - clear-block treated as store everywhere
// - clear hit zeroes line, marks modified
// - clear miss allocates zeroed line, no read
// - inhibited/write-through clear: zero memory or exception
// - coherent clear issues bus kill transaction
`ifndef DTZ_CFG_SVH
`define DTZ_CFG_SVH

`define DTZ_PRIMARY_OP 6'h1F
`define DTZ_XO_TOUCH_LD 10'h116
`define DTZ_XO_TOUCH_ST 10'h0F6
`define DTZ_XO_ZERO 10'h3F6
`define DTZ_BLOCK_BYTES 32

`define DTZ_REG_CTRL 12'h000
`define DTZ_REG_STATUS 12'h004
`define DTZ_REG_DROPS 12'h008
`define DTZ_REG_ZEROS 12'h00C

`define DTZ_CTRL_LCE 0
`define DTZ_CTRL_TOUCH_EN 1
`define DTZ_CTRL_ZMEM 2
`define DTZ_CTRL_RESET 32'h0000_0002

`define DTZ_ST_BUSY 0
`define DTZ_ST_EXC 1
`define DTZ_ST_DSI 2

`endif

// ==== shared/dtz_pkg.sv ====
package dtz_pkg;
	typedef enum logic [1:0] {
		DTZ_OP_NONE,
		DTZ_OP_TOUCH_LD,
		DTZ_OP_TOUCH_ST,
		DTZ_OP_ZERO
	} dtz_op_t;

	typedef enum logic [1:0] {
		DTZ_BUS_READ,
		DTZ_BUS_READ_MOD,
		DTZ_BUS_KILL,
		DTZ_BUS_ZERO_WRITE
	} dtz_bus_t;

	typedef enum logic {
		DTZ_COP_FILL,
		DTZ_COP_ZERO
	} dtz_cop_t;

	typedef enum logic [2:0] {
		DTZ_S_IDLE,
		DTZ_S_XLAT,
		DTZ_S_BUS,
		DTZ_S_CACHE,
		DTZ_S_DONE
	} dtz_state_t;
endpackage

// ==== src/dtz_decode.sv ====
`timescale 1ns/1ps
`include "dtz_cfg.svh"
module dtz_decode
	import dtz_pkg::*;
#(
	parameter int BLOCK_BYTES = `DTZ_BLOCK_BYTES
)(
	// instruction and operands
	input wire logic [31:0] instr,
	input wire logic [31:0] base_gpr,
	input wire logic [31:0] index_gpr,
	// decoded result
	output dtz_op_t op,
	output logic [31:0] effective_address,
	output logic [31:0] block_address
);
	localparam int OFS_W = $clog2(BLOCK_BYTES);

	logic primary_ok;
	logic [9:0] xo;
	logic [4:0] base_field;
	logic [4:0] mid_field;

	assign primary_ok = instr[31:26] == `DTZ_PRIMARY_OP;
	assign mid_field = instr[25:21];
	assign base_field = instr[20:16];
	assign xo = instr[10:1];

	// bits 6..10 must be zero for all three; bit 31 for touches
	always_comb
	begin
		op = DTZ_OP_NONE;
		if (primary_ok && mid_field == 5'h00)
		begin
			if (xo == `DTZ_XO_TOUCH_LD && !instr[0])
				op = DTZ_OP_TOUCH_LD;
			else if (xo == `DTZ_XO_TOUCH_ST && !instr[0])
				op = DTZ_OP_TOUCH_ST;
			else if (xo == `DTZ_XO_ZERO)
				op = DTZ_OP_ZERO;
		end
	end

	// field value zero selects a literal zero, not register zero
	assign effective_address = (base_field == 5'h00 ? 32'h0000_0000
		: base_gpr) + index_gpr;

	// same block size used for alignment and the zeroing span
	assign block_address = {effective_address[31:OFS_W],
		{OFS_W{1'b0}}};
endmodule

// ==== src/dtz_block_ops.sv ====
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "dtz_cfg.svh"
module dtz_block_ops
	import dtz_pkg::*;
#(
	parameter int BLOCK_BYTES = `DTZ_BLOCK_BYTES,
	parameter int CNT_W = 16
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// instruction issue
	input wire logic issue_valid,
	output logic issue_ready,
	input wire logic [31:0] issue_instr,
	input wire logic [31:0] base_gpr,
	input wire logic [31:0] index_gpr,
	// completion
	output logic done_valid,
	output logic done_noop,
	output logic done_align_exc,
	output logic done_dsi,
	// translation and cache lookup
	output logic xlat_req,
	output logic [31:0] xlat_ea,
	output logic xlat_store,
	output logic xlat_rc_update,
	input wire logic xlat_ack,
	input wire logic xlat_fault,
	input wire logic xlat_inhibited,
	input wire logic xlat_write_through,
	input wire logic xlat_coherent,
	input wire logic [31:0] xlat_paddr,
	input wire logic hit_locked,
	input wire logic hit_normal,
	// cache array operation
	output logic cop_valid,
	input wire logic cop_ready,
	output dtz_cop_t cop_kind,
	output logic [31:0] cop_addr,
	output logic [15:0] cop_bytes,
	output logic cop_alloc,
	output logic cop_normal_only,
	output logic cop_set_modified,
	// system bus
	output logic bus_req,
	input wire logic bus_ack,
	output dtz_bus_t bus_kind,
	output logic [31:0] bus_addr,
	output logic [15:0] bus_bytes
);
	initial
	begin
		if (BLOCK_BYTES < 4 || BLOCK_BYTES > 4096 ||
			(BLOCK_BYTES & (BLOCK_BYTES - 1)) != 0)
			$error("block size must be a power of two, 4..4096");
		if (CNT_W < 1 || CNT_W > 32)
			$error("counter width must be 1..32");
	end

	localparam logic [15:0] BLK_B = 16'(BLOCK_BYTES);

	dtz_state_t state_q;
	dtz_op_t dec_op;
	dtz_op_t op_q;
	logic [31:0] dec_ea;
	logic [31:0] dec_blk;
	logic [31:0] ea_q;
	logic [31:0] ctrl_q;
	logic [CNT_W-1:0] drops_q;
	logic [CNT_W-1:0] zeros_q;
	logic exc_q;
	logic dsi_q;
	logic noop_q;
	logic is_touch_q;
	logic is_touch;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic take;
	logic drop_now;
	logic zero_done;
	logic locked_cache_enable;
	logic touch_en;
	logic zero_mem;

	dtz_decode #(
		.BLOCK_BYTES(BLOCK_BYTES)
	) u_decode (
		.instr(issue_instr),
		.base_gpr(base_gpr),
		.index_gpr(index_gpr),
		.op(dec_op),
		.effective_address(dec_ea),
		.block_address(dec_blk)
	);

	assign locked_cache_enable = ctrl_q[`DTZ_CTRL_LCE];
	assign touch_en = ctrl_q[`DTZ_CTRL_TOUCH_EN];
	assign zero_mem = ctrl_q[`DTZ_CTRL_ZMEM];
	assign is_touch = dec_op == DTZ_OP_TOUCH_LD ||
		dec_op == DTZ_OP_TOUCH_ST;

	// apb: zero wait states, error on unmapped offsets
	assign mapped = paddr == `DTZ_REG_CTRL || paddr == `DTZ_REG_STATUS ||
		paddr == `DTZ_REG_DROPS || paddr == `DTZ_REG_ZEROS;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_en = psel && !penable && !pwrite;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_q <= `DTZ_CTRL_RESET;
		else if (wr_en && paddr == `DTZ_REG_CTRL)
			ctrl_q <= pwdata & 32'h0000_0007;
	end

	// read data captured in setup so it is stable in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_en)
		begin
			unique case (paddr)
				`DTZ_REG_CTRL: prdata <= ctrl_q;
				`DTZ_REG_STATUS: prdata <= {29'h0000_0000, dsi_q, exc_q,
					state_q != DTZ_S_IDLE};
				`DTZ_REG_DROPS: prdata <= 32'(drops_q);
				`DTZ_REG_ZEROS: prdata <= 32'(zeros_q);
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	assign issue_ready = state_q == DTZ_S_IDLE;
	assign take = issue_valid && issue_ready;
	assign xlat_req = state_q == DTZ_S_XLAT;
	assign bus_req = state_q == DTZ_S_BUS;
	assign cop_valid = state_q == DTZ_S_CACHE;
	assign done_valid = state_q == DTZ_S_DONE;
	assign done_noop = noop_q;
	assign done_align_exc = exc_q;
	assign done_dsi = dsi_q;
	assign xlat_ea = ea_q;

	// translation sees the clear as a store, touches as loads
	assign xlat_store = op_q == DTZ_OP_ZERO;
	// touches leave referenced/changed bits alone
	assign xlat_rc_update = op_q == DTZ_OP_ZERO;

	// dropped touch: disabled, faulted or inhibited
	assign drop_now = (take && is_touch && !touch_en) || (xlat_req &&
		xlat_ack && is_touch_q && (xlat_fault || xlat_inhibited));
	assign zero_done = cop_valid && cop_ready && cop_kind == DTZ_COP_ZERO;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= DTZ_S_IDLE;
			op_q <= DTZ_OP_NONE;
			ea_q <= 32'h0000_0000;
			is_touch_q <= 1'b0;
			noop_q <= 1'b0;
			exc_q <= 1'b0;
			dsi_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				DTZ_S_IDLE:
					if (take)
					begin
						op_q <= dec_op;
						ea_q <= dec_ea;
						is_touch_q <= is_touch;
						exc_q <= 1'b0;
						dsi_q <= 1'b0;
						noop_q <= dec_op == DTZ_OP_NONE ||
							(is_touch && !touch_en);
						// dropping a hint is invisible to software
						if (dec_op == DTZ_OP_NONE || (is_touch && !touch_en))
							state_q <= DTZ_S_DONE;
						else
							state_q <= DTZ_S_XLAT;
					end
				DTZ_S_XLAT:
					if (xlat_ack)
					begin
						if (is_touch_q)
						begin
							// faults and inhibited pages end quietly
							if (xlat_fault || xlat_inhibited)
							begin
								noop_q <= 1'b1;
								state_q <= DTZ_S_DONE;
							end
							else if (hit_locked || hit_normal)
								state_q <= DTZ_S_DONE;
							else
								state_q <= DTZ_S_BUS;
						end
						else if (xlat_fault)
						begin
							dsi_q <= 1'b1;
							state_q <= DTZ_S_DONE;
						end
						else if (xlat_inhibited || xlat_write_through)
						begin
							if (zero_mem)
								state_q <= DTZ_S_BUS;
							else
							begin
								exc_q <= 1'b1;
								state_q <= DTZ_S_DONE;
							end
						end
						// coherent line: kill other copies before zeroing
						else if (xlat_coherent)
							state_q <= DTZ_S_BUS;
						else
							state_q <= DTZ_S_CACHE;
					end
				DTZ_S_BUS:
					if (bus_ack)
					begin
						if (bus_kind == DTZ_BUS_ZERO_WRITE)
							state_q <= DTZ_S_DONE;
						else
							state_q <= DTZ_S_CACHE;
					end
				DTZ_S_CACHE:
					if (cop_ready)
						state_q <= DTZ_S_DONE;
				DTZ_S_DONE:
					state_q <= DTZ_S_IDLE;
			endcase
		end
	end

	// bus request fields, set once translation answers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_kind <= DTZ_BUS_READ;
			bus_addr <= 32'h0000_0000;
			bus_bytes <= 16'h0000;
		end
		else if (xlat_req && xlat_ack)
		begin
			bus_addr <= {xlat_paddr[31:$clog2(BLOCK_BYTES)],
				{$clog2(BLOCK_BYTES){1'b0}}};
			bus_bytes <= BLK_B;
			// the two touches differ only in intent on the bus
			if (op_q == DTZ_OP_TOUCH_ST)
				bus_kind <= DTZ_BUS_READ_MOD;
			else if (op_q == DTZ_OP_TOUCH_LD)
				bus_kind <= DTZ_BUS_READ;
			else if (xlat_inhibited || xlat_write_through)
				bus_kind <= DTZ_BUS_ZERO_WRITE;
			else
				bus_kind <= DTZ_BUS_KILL;
		end
	end

	// cache operation fields
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cop_kind <= DTZ_COP_FILL;
			cop_addr <= 32'h0000_0000;
			cop_bytes <= 16'h0000;
			cop_alloc <= 1'b0;
			cop_normal_only <= 1'b0;
			cop_set_modified <= 1'b0;
		end
		else if (xlat_req && xlat_ack)
		begin
			cop_addr <= {xlat_paddr[31:$clog2(BLOCK_BYTES)],
				{$clog2(BLOCK_BYTES){1'b0}}};
			cop_bytes <= BLK_B;
			if (is_touch_q)
			begin
				cop_kind <= DTZ_COP_FILL;
				cop_alloc <= 1'b1;
				// locked mode: a miss in both goes to the normal part
				cop_normal_only <= locked_cache_enable;
				cop_set_modified <= 1'b0;
			end
			else
			begin
				// zero without a memory read; hit or allocate
				cop_kind <= DTZ_COP_ZERO;
				cop_alloc <= !(hit_locked || hit_normal);
				cop_normal_only <= locked_cache_enable &&
					!hit_locked;
				cop_set_modified <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			drops_q <= '0;
		else if (wr_en && paddr == `DTZ_REG_DROPS)
			drops_q <= '0;
		else if (drop_now)
			drops_q <= drops_q + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			zeros_q <= '0;
		else if (wr_en && paddr == `DTZ_REG_ZEROS)
			zeros_q <= '0;
		else if (zero_done)
			zeros_q <= zeros_q + 1'b1;
	end
endmodule

// ==== sim/dtz_block_ops_asserts.sv ====
`timescale 1ns/1ps
`include "dtz_cfg.svh"
module dtz_chk
	import dtz_pkg::*;
#(
	parameter int BLOCK_BYTES = 32
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// issue and completion
	input wire logic issue_valid,
	input wire logic issue_ready,
	input wire logic [31:0] issue_instr,
	input wire logic [31:0] base_gpr,
	input wire logic [31:0] index_gpr,
	input wire logic done_valid,
	input wire logic done_noop,
	input wire logic done_align_exc,
	input wire logic done_dsi,
	// translation
	input wire logic xlat_req,
	input wire logic xlat_ack,
	input wire logic xlat_inhibited,
	input wire logic [31:0] xlat_ea,
	input wire logic xlat_store,
	input wire logic xlat_rc_update,
	// cache and bus
	input wire logic cop_valid,
	input dtz_cop_t cop_kind,
	input wire logic [31:0] cop_addr,
	input wire logic [15:0] cop_bytes,
	input wire logic cop_set_modified,
	input wire logic bus_req,
	input dtz_bus_t bus_kind
);
	logic zero_q;
	logic [31:0] ea_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// operation and address of the one outstanding issue
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			zero_q <= 1'b0;
			ea_q <= 32'h0;
		end
		else if (issue_valid && issue_ready)
		begin
			zero_q <= issue_instr[10:1] == `DTZ_XO_ZERO;
			ea_q <= (issue_instr[20:16] == 5'h00 ? 32'h0 : base_gpr)
				+ index_gpr;
		end
	end

	chk_ea_form: assert property (
		xlat_req |-> xlat_ea == ea_q)
		else $error("effective address wrong");
	chk_touch_load: assert property (
		xlat_req && !zero_q |-> !xlat_store)
		else $error("touch translated as store");
	chk_zero_store: assert property (
		xlat_req && zero_q |-> xlat_store && xlat_rc_update)
		else $error("clear not translated as store");
	chk_touch_noexc: assert property (
		done_valid && !zero_q |-> !done_align_exc && !done_dsi)
		else $error("touch raised exception");
	chk_inh_noop: assert property (
		xlat_req && xlat_ack && xlat_inhibited && !zero_q |->
		##[1:3] done_valid && done_noop)
		else $error("inhibited touch not a no-op");
	chk_zero_noread: assert property (
		bus_req && zero_q |->
		bus_kind inside {DTZ_BUS_KILL, DTZ_BUS_ZERO_WRITE})
		else $error("clear read memory");
	chk_touch_kind: assert property (
		bus_req && !zero_q |->
		bus_kind inside {DTZ_BUS_READ, DTZ_BUS_READ_MOD})
		else $error("touch bus kind wrong");
	chk_zero_mod: assert property (
		cop_valid && cop_kind == DTZ_COP_ZERO |-> cop_set_modified)
		else $error("zeroed line not modified");
	chk_block_span: assert property (
		cop_valid |-> cop_bytes == 16'(BLOCK_BYTES) &&
		(cop_addr & (BLOCK_BYTES - 1)) == 0)
		else $error("block span or alignment wrong");

	cover property (done_valid && done_align_exc);
	cover property (done_valid && done_noop);
	cover property (done_valid && done_dsi);
endmodule

bind dtz_block_ops dtz_chk #(.BLOCK_BYTES(BLOCK_BYTES)) u_chk (.*);

// ==== sim/dtz_far_model.sv ====
`timescale 1ns/1ps
module dtz_far_model (
	// clock and bench controls
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic [5:0] attr,
	// requests
	input wire logic xlat_req,
	input wire logic [31:0] xlat_ea,
	input wire logic bus_req,
	input wire logic cop_valid,
	// answers
	output logic xlat_ack,
	output logic xlat_fault,
	output logic xlat_inhibited,
	output logic xlat_write_through,
	output logic xlat_coherent,
	output logic [31:0] xlat_paddr,
	output logic hit_locked,
	output logic hit_normal,
	output logic bus_ack,
	output logic cop_ready
);
	logic [1:0] wait_q;
	logic go;

	// one counter serves all, only one request is ever open
	assign go = !slow || wait_q == 2'h3;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wait_q <= 2'h0;
		else if ((xlat_req || bus_req || cop_valid) && !go)
			wait_q <= wait_q + 2'h1;
		else
			wait_q <= 2'h0;
	end

	assign xlat_ack = xlat_req && go;
	// attributes hold only with the ack, inverted otherwise
	assign {xlat_fault, xlat_inhibited, xlat_write_through, xlat_coherent,
		hit_locked, hit_normal} = xlat_ack ? attr : ~attr;
	assign xlat_paddr = xlat_ack ? xlat_ea : ~xlat_ea;
	assign bus_ack = bus_req && go;
	assign cop_ready = cop_valid && go;
endmodule

// ==== sim/dtz_block_ops_tb.sv ====
`timescale 1ns/1ps
module dtz_block_ops_tb
	import dtz_pkg::*;
;
	localparam int BB = 32;
	localparam logic [9:0] TL = 10'h116;
	localparam logic [9:0] TS = 10'h0F6;
	localparam logic [9:0] TZ = 10'h3F6;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic issue_valid = 0, slow = 0, te = 1, e, ck, cn, al;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, issue_instr = 32'h0, rd, ba, ca;
	logic [31:0] base_gpr = 32'h0000_4000, index_gpr = 32'h0000_1003;
	logic [5:0] attr = 6'h00;
	logic [1:0] bk;
	logic [31:0] prdata, xlat_ea, xlat_paddr, cop_addr, bus_addr;
	logic [15:0] cop_bytes, bus_bytes, bz;
	logic pready, pslverr, issue_ready, done_valid, done_noop;
	logic done_align_exc, done_dsi, xlat_req, xlat_store, xlat_rc_update;
	logic xlat_ack, xlat_fault, xlat_inhibited, xlat_write_through;
	logic xlat_coherent, hit_locked, hit_normal, cop_valid, cop_ready;
	logic cop_alloc, cop_normal_only, cop_set_modified, bus_req, bus_ack;
	dtz_cop_t cop_kind;
	dtz_bus_t bus_kind;
	int err_total = 0, samples_checked = 0, nx, nb, nc, p;

	dtz_block_ops #(.BLOCK_BYTES(BB)) u_dtz_block_ops (.*);
	dtz_far_model u_dtz_far_model (.*);

	always #2.5 pclk = ~pclk;

	always @(posedge pclk)
	begin
		nx += int'(xlat_req && xlat_ack);
		if (bus_req && bus_ack)
		begin
			nb++;
			bk = bus_kind;
			ba = bus_addr;
			bz = bus_bytes;
		end
		if (cop_valid && cop_ready)
		begin
			nc++;
			ck = cop_kind;
			cn = cop_normal_only;
			ca = cop_addr;
			al = cop_alloc;
		end
	end

	task automatic give_verdict();
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic hang();
		err_total++;
		$display("BAD %0t timeout", $time);
		give_verdict();
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 50)
			hang();
	endtask

	// one issue; counts of handshakes seen until completion
	task automatic run(input logic [9:0] xo, input logic [4:0] ra,
		input logic [5:0] at, input logic [2:0] ef, input int enb,
		input logic [1:0] ek, input int enc, input logic en);
		logic [31:0] ea;
		int i;
		ea = ((ra == 5'h00 ? 32'h0 : base_gpr) + index_gpr) & ~(BB - 1);
		@(posedge pclk);
		nx = 0;
		nb = 0;
		nc = 0;
		attr <= at;
		issue_instr <= {6'h1F, 5'h00, ra, 5'h01, xo, 1'b0};
		issue_valid <= 1'b1;
		@(posedge pclk);
		cmp(issue_ready, 1);
		issue_valid <= 1'b0;
		for (i = 0; i < 200; i++)
		begin
			@(posedge pclk);
			if (done_valid === 1'b1)
				break;
		end
		if (i == 200)
			hang();
		cmp({done_noop, done_align_exc, done_dsi}, ef);
		cmp(nx, xo == TZ || (te && xo inside {TL, TS}));
		cmp(nb, enb);
		cmp(nc, enc);
		if (enb > 0)
		begin
			cmp(bk, ek);
			cmp(ba, ea);
			cmp(bz, BB);
		end
		if (enc > 0)
		begin
			cmp(ck, xo == TZ);
			cmp(cn, en);
			cmp(ca, ea);
			cmp(al, !(at[1] || at[0]));
		end
	endtask

	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h000, 32'h0);
		cmp(rd, 32'h2);
		apb(0, 12'h004, 32'h0);
		cmp(rd, 32'h0);
		apb(1, 12'h010, 32'hFFFF_FFFF);
		cmp(e, 1);
		apb(0, 12'h010, 32'h0);
		cmp(rd, 32'h0);
		for (p = 0; p < 2; p++)
		begin
			// second pass with a slow far side
			slow <= p[0];
			apb(1, 12'h000, 32'h3);
			run(TL, 0, 6'h00, 3'h0, 1, 0, 1, 1);
			run(TS, 1, 6'h00, 3'h0, 1, 1, 1, 1);
			run(TL, 0, 6'h10, 3'h4, 0, 0, 0, 0);
			run(TS, 0, 6'h20, 3'h4, 0, 0, 0, 0);
			run(TL, 1, 6'h01, 3'h0, 0, 0, 0, 0);
			run(TZ, 0, 6'h02, 3'h0, 0, 0, 1, 0);
			run(TZ, 1, 6'h04, 3'h0, 1, 2, 1, 1);
			run(TZ, 0, 6'h10, 3'h2, 0, 0, 0, 0);
			run(TZ, 0, 6'h20, 3'h1, 0, 0, 0, 0);
			run(10'h036, 0, 6'h00, 3'h4, 0, 0, 0, 0);
			apb(1, 12'h000, 32'h6);
			run(TZ, 1, 6'h08, 3'h0, 1, 3, 0, 0);
			run(TZ, 0, 6'h00, 3'h0, 0, 0, 1, 0);
		end
		// touches disabled, alignment exception mode for the clear
		apb(1, 12'h000, 32'h1);
		te = 1'b0;
		run(TS, 0, 6'h00, 3'h4, 0, 0, 0, 0);
		run(TZ, 0, 6'h10, 3'h2, 0, 0, 0, 0);
		apb(0, 12'h004, 32'h0);
		cmp(rd, 32'h2);
		apb(0, 12'h008, 32'h0);
		cmp(rd, 32'h5);
		apb(0, 12'h00C, 32'h0);
		cmp(rd, 32'h6);
		apb(1, 12'h008, 32'h0);
		apb(0, 12'h008, 32'h0);
		cmp(rd, 32'h0);
		// second reset: control and the zero counter back to their reset values
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h000, 32'h0);
		cmp(rd, 32'h2);
		apb(0, 12'h00C, 32'h0);
		cmp(rd, 32'h0);
		give_verdict();
	end
endmodule
